//--- hw/scd_pkg.sv
package scd_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int NBANK = 8;
  localparam int BA_W  = 3;
  localparam int ROW_W = 15;
  localparam int COL_W = 10;
  localparam int DQ_W  = 8;
  localparam int BL8   = 8;
  localparam int BC4   = 4;
  localparam int A_AP  = 10;
  localparam int A_BC  = 12;
  localparam int PA_W  = 8;
  localparam logic [2:0] LAST_BL8 = 3'(BL8 - 1);
  localparam logic [2:0] LAST_BC4 = 3'(BC4 - 1);

  // ****************************************
  // Registers
  // ****************************************
  localparam logic [PA_W-1:0] REG_CTRL = 8'h00;
  localparam logic [PA_W-1:0] REG_STAT = 8'h04;
  localparam logic [PA_W-1:0] REG_LAST = 8'h08;
  localparam int CT_OTF  = 0;
  localparam int CT_BC4  = 1;
  localparam int CT_ILV  = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam int ST_OPEN = 0;
  localparam int ST_PWR  = 8;
  localparam int ST_BUSY = 10;
  localparam int ST_ILL  = 11;
  localparam int ST_OVF  = 12;
  localparam int LA_BANK = 4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    C_NOP = 4'h0, C_ACT = 4'h1, C_RD  = 4'h2, C_WR  = 4'h3,
    C_PRE = 4'h4, C_PREA = 4'h5, C_MRS = 4'h6, C_REF = 4'h7,
    C_SRE = 4'h8, C_SRX = 4'h9, C_PDE = 4'hA, C_PDX = 4'hB,
    C_ZQL = 4'hC, C_ZQS = 4'hD, C_ILL = 4'hE
  } scd_cmd_t;

  typedef enum logic [1:0] {
    P_ON = 2'b00, P_PD = 2'b01, P_SR = 2'b10
  } scd_pwr_t;

endpackage

//--- hw/scd_decoder.sv
// Operation
// - Read: CS low, RAS high, CAS low, WE high, CKE high twice, bank open.
// - Write like read with WE low; A12 low chops to four, high eight.
// - Activate takes bank and row; precharge closes one, A10 high all.
// - Read or write column address is the burst's starting column.
// - A10 on read or write closes the bank after the burst.
// - A12 chop honoured only when on-the-fly enabled; else fixed length.
// - Mode register set only with all banks idle, all strobes low.
// - Power-down entry: idle, CKE high then low, no-op or deselect.
// - Power-down or self-refresh exit: CKE low then high, no-op.
// - During a write burst, beats with mask high stored, low dropped.
// - Previous CKE is the level registered one clock before the command.
// - Bank preconditions apply to the addressed bank; state per bank.
// - Eight banks, each opened and closed on its own.
// - Bursts start at column, eight or four beats, programmed order.
// - One prefetch word of eight beats, two beats per clock.
module scd_decoder #(
  parameter int DEPTH = 2
) (
  input  wire logic                       MCLK_I,
  input  wire logic                       RESETN_I,
  input  wire logic                       CK_I,
  input  wire logic                       CKE_I,
  input  wire logic                       CS_N_I,
  input  wire logic                       RAS_N_I,
  input  wire logic                       CAS_N_I,
  input  wire logic                       WE_N_I,
  input  wire logic [scd_pkg::BA_W-1:0]   BA_I,
  input  wire logic [scd_pkg::ROW_W-1:0]  A_I,
  input  wire logic                       DM_I,
  input  wire logic [scd_pkg::DQ_W-1:0]   DQ_I,
  input  wire logic                       PSEL_I,
  input  wire logic                       PENABLE_I,
  input  wire logic                       PWRITE_I,
  input  wire logic [scd_pkg::PA_W-1:0]   PADDR_I,
  input  wire logic [31:0]                PWDATA_I,
  output logic      [31:0]                PRDATA_O,
  output logic                            PREADY_O,
  output logic                            PSLVERR_O,
  output logic                            CMD_STB_O,
  output logic      [3:0]                 CMD_CODE_O,
  output logic      [scd_pkg::BA_W-1:0]   CMD_BANK_O,
  output logic      [scd_pkg::ROW_W-1:0]  CMD_ADDR_O,
  output logic                            CMD_AP_O,
  output logic                            CMD_BC4_O,
  output logic                            WORD_VALID_O,
  input  wire logic                       WORD_READY_I,
  output logic      [8*scd_pkg::DQ_W-1:0] WORD_DATA_O,
  output logic      [7:0]                 WORD_KEEP_O,
  output logic      [scd_pkg::BA_W-1:0]   WORD_BANK_O,
  output logic      [scd_pkg::ROW_W-1:0]  WORD_ROW_O,
  output logic      [scd_pkg::COL_W-1:0]  WORD_COL_O
);
  import scd_pkg::*;

  localparam int SW = 6 + BA_W + ROW_W + 1 + DQ_W;
  localparam int DW = 8 * DQ_W;
  localparam int EW = BA_W + ROW_W + COL_W + 8 + DW;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two, at least 2");
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);

  // ****************************************
  // Pin synchroniser and clock edges
  // ****************************************
  logic [SW-1:0]      s1_q, s2_q;
  logic               ck_q, ck, cke, cs_n, ras_n, cas_n, we_n, dm;
  logic [BA_W-1:0]    ba;
  logic [ROW_W-1:0]   a;
  logic [DQ_W-1:0]    dq;
  logic               rise, fall;

  // Two stages on every pin, third stage on the clock for edges
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s1_q <= '0;
      s2_q <= '0;
      ck_q <= 1'b0;
    end else begin
      s1_q <= {CK_I, CKE_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I,
               BA_I, A_I, DM_I, DQ_I};
      s2_q <= s1_q;
      ck_q <= s2_q[SW-1];
    end
  end

  assign {ck, cke, cs_n, ras_n, cas_n, we_n, ba, a, dm, dq} = s2_q;
  assign rise = ck & ~ck_q;
  assign fall = ~ck & ck_q;

  // ****************************************
  // Command decode
  // ****************************************
  logic [NBANK-1:0]   open_q, open_d;
  logic               ckep_q, ckep_d;
  scd_pwr_t           pwr_q, pwr_d;
  scd_cmd_t           code;
  logic               nopdes, idle, bc4_w;
  logic [2:0]         ctrl_q, ctrl_d;

  assign idle = ~|open_q;
  // Chop from A12 only when on-the-fly is enabled
  assign bc4_w = ctrl_q[CT_OTF] ? ~a[A_BC] : ctrl_q[CT_BC4];

  // Truth table on the sampled command lines
  always_comb begin
    code = C_NOP;
    nopdes = cs_n | (ras_n & cas_n & we_n);
    if (pwr_q != P_ON) begin
      if (!ckep_q && cke && nopdes) begin
        code = (pwr_q == P_SR) ? C_SRX : C_PDX;
      end
    end else if (ckep_q && !cke) begin
      if (nopdes && idle) begin
        code = C_PDE;
      end else if (!cs_n && {ras_n, cas_n, we_n} == 3'b001 && idle) begin
        code = C_SRE;
      end else begin
        code = C_ILL;
      end
    end else if (ckep_q && !cs_n) begin
      unique case ({ras_n, cas_n, we_n})
        3'b111: code = C_NOP;
        3'b011: code = open_q[ba] ? C_ILL : C_ACT;
        3'b010: code = a[A_AP] ? C_PREA : C_PRE;
        3'b101: code = open_q[ba] ? C_RD : C_ILL;
        3'b100: code = open_q[ba] ? C_WR : C_ILL;
        3'b000: code = idle ? C_MRS : C_ILL;
        3'b001: code = idle ? C_REF : C_ILL;
        3'b110: code = !idle ? C_ILL : (a[A_AP] ? C_ZQL : C_ZQS);
      endcase
    end
  end

  // ****************************************
  // Bank, power and command report
  // ****************************************
  logic [NBANK-1:0][ROW_W-1:0] row_q, row_d;
  logic               stb_q, stb_d, cap_q, cap_d, cbc_q, cbc_d;
  logic [3:0]         cc_q, cc_d;
  logic [BA_W-1:0]    cb_q, cb_d;
  logic [ROW_W-1:0]   ca_q, ca_d;
  logic               ill_q, ill_d, ovf_q, ovf_d, w_stat, done;
  logic               ap_q;
  logic [BA_W-1:0]    b_q;

  // Bank table update on each rising link clock edge; auto-precharge close on the last beat's fall
  always_comb begin
    open_d = open_q;
    row_d = row_q;
    pwr_d = pwr_q;
    ckep_d = ckep_q;
    stb_d = 1'b0;
    cc_d = cc_q;
    cb_d = cb_q;
    ca_d = ca_q;
    cap_d = cap_q;
    cbc_d = cbc_q;
    ill_d = ill_q & ~(w_stat & PWDATA_I[ST_ILL]);
    if (rise) begin
      ckep_d = cke;
      if (code != C_NOP) begin
        stb_d = 1'b1;
        cc_d = code;
        cb_d = ba;
        ca_d = a;
        cap_d = a[A_AP];
        cbc_d = bc4_w;
      end
      if (code == C_ACT) begin
        open_d[ba] = 1'b1;
        row_d[ba] = a;
      end
      if (code == C_PRE) open_d[ba] = 1'b0;
      if (code == C_PREA) open_d = '0;
      if (code == C_PDE) pwr_d = P_PD;
      if (code == C_SRE) pwr_d = P_SR;
      if (code == C_PDX || code == C_SRX) pwr_d = P_ON;
      if (code == C_ILL) ill_d = 1'b1;
    end
    if (done && ap_q) open_d[b_q] = 1'b0;
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      open_q <= '0;
      row_q <= '0;
      pwr_q <= P_ON;
      ckep_q <= 1'b0;
      stb_q <= 1'b0;
      cc_q <= 4'h0;
      cb_q <= '0;
      ca_q <= '0;
      cap_q <= 1'b0;
      cbc_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      open_q <= open_d;
      row_q <= row_d;
      pwr_q <= pwr_d;
      ckep_q <= ckep_d;
      stb_q <= stb_d;
      cc_q <= cc_d;
      cb_q <= cb_d;
      ca_q <= ca_d;
      cap_q <= cap_d;
      cbc_q <= cbc_d;
      ill_q <= ill_d;
    end
  end

  // ****************************************
  // Burst engine and prefetch word
  // ****************************************
  logic               arm_q, arm_d, busy_q, busy_d, wr_q, wr_d, ap_d, cap;
  logic [2:0]         idx_q, idx_d, last_q, last_d, lane;
  logic [COL_W-1:0]   col_q, col_d;
  logic [BA_W-1:0]    b_d;
  logic [DW-1:0]      dat_q, dat_d, wdat;
  logic [7:0]         keep_q, keep_d, wkeep;

  // Beat position in the word for the programmed order
  function automatic logic [2:0] lane_f(logic [2:0] c, logic [2:0] i,
                                        logic ilv);
    lane_f = ilv ? (c ^ i) : {c[2] ^ i[2], 2'(c[1:0] + i[1:0])};
  endfunction

  assign cap = (rise & arm_q) | ((rise | fall) & busy_q);
  assign lane = lane_f(col_q[2:0], idx_q, ctrl_q[CT_ILV]);

  // One beat on each link clock half from the rise after the command
  always_comb begin
    arm_d = arm_q;
    busy_d = busy_q;
    idx_d = idx_q;
    last_d = last_q;
    wr_d = wr_q;
    col_d = col_q;
    b_d = b_q;
    ap_d = ap_q;
    wdat = dat_q;
    wkeep = keep_q;
    done = 1'b0;
    if (cap) begin
      arm_d = 1'b0;
      busy_d = 1'b1;
      if (wr_q && dm) begin
        wdat[lane*DQ_W +: DQ_W] = dq;
        wkeep[lane] = 1'b1;
      end
      idx_d = 3'(idx_q + 3'h1);
      if (idx_q == last_q) begin
        done = 1'b1;
        busy_d = 1'b0;
      end
    end
    dat_d = wdat;
    keep_d = wkeep;
    if (rise && (code == C_RD || code == C_WR)) begin
      arm_d = 1'b1;
      busy_d = 1'b0;
      idx_d = 3'h0;
      last_d = bc4_w ? LAST_BC4 : LAST_BL8;
      wr_d = (code == C_WR);
      col_d = a[COL_W-1:0];
      b_d = ba;
      ap_d = a[A_AP];
      dat_d = '0;
      keep_d = '0;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      arm_q <= 1'b0;
      busy_q <= 1'b0;
      idx_q <= 3'h0;
      last_q <= LAST_BL8;
      wr_q <= 1'b0;
      col_q <= '0;
      b_q <= '0;
      ap_q <= 1'b0;
      dat_q <= '0;
      keep_q <= 8'h00;
    end else begin
      arm_q <= arm_d;
      busy_q <= busy_d;
      idx_q <= idx_d;
      last_q <= last_d;
      wr_q <= wr_d;
      col_q <= col_d;
      b_q <= b_d;
      ap_q <= ap_d;
      dat_q <= dat_d;
      keep_q <= keep_d;
    end
  end

  // ****************************************
  // Word buffer
  // ****************************************
  logic [DEPTH-1:0][EW-1:0] mem_q;
  logic [PW-1:0]      wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]        cnt_q, cnt_d;
  logic               push, full, pop;

  assign push = done & wr_q;
  assign full = (cnt_q == (PW+1)'(DEPTH));
  assign pop = (cnt_q != '0) & WORD_READY_I;

  // Pointers; a word arriving on a full buffer is counted as lost
  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    ovf_d = (ovf_q & ~(w_stat & PWDATA_I[ST_OVF])) | (push & full);
    if (push && !full) wp_d = PW'(wp_q + 1'b1);
    if (pop) rp_d = PW'(rp_q + 1'b1);
    if ((push && !full) && !pop) cnt_d = (PW+1)'(cnt_q + 1'b1);
    if (!(push && !full) && pop) cnt_d = (PW+1)'(cnt_q - 1'b1);
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mem_q <= '0;
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      if (push && !full) mem_q[wp_q] <= {b_q, row_q[b_q], col_q, wkeep, wdat};
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  assign WORD_VALID_O = (cnt_q != '0);
  assign {WORD_BANK_O, WORD_ROW_O, WORD_COL_O, WORD_KEEP_O, WORD_DATA_O} =
         mem_q[rp_q];

  // ****************************************
  // APB slave
  // ****************************************
  logic [31:0]        prd_q, prd_d;
  logic               hit, setup, acc;

  assign setup = PSEL_I & ~PENABLE_I;
  assign acc = PSEL_I & PENABLE_I;
  assign hit = (PADDR_I == REG_CTRL) | (PADDR_I == REG_STAT) |
               (PADDR_I == REG_LAST);
  assign w_stat = acc & PWRITE_I & (PADDR_I == REG_STAT);

  // Read data latched in the setup cycle, writes land in access
  always_comb begin
    prd_d = prd_q;
    ctrl_d = ctrl_q;
    if (setup) begin
      prd_d = 32'h0;
      if (PADDR_I == REG_CTRL) prd_d = 32'(ctrl_q);
      if (PADDR_I == REG_STAT) begin
        prd_d = 32'({ovf_q, ill_q, busy_q | arm_q, pwr_q, open_q});
      end
      if (PADDR_I == REG_LAST) prd_d = 32'({cb_q, cc_q});
    end
    if (acc && PWRITE_I && PADDR_I == REG_CTRL) ctrl_d = PWDATA_I[2:0];
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prd_q <= 32'h0;
      ctrl_q <= CTRL_RST;
    end else begin
      prd_q <= prd_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign PRDATA_O = prd_q;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc & ~hit;
  assign CMD_STB_O = stb_q;
  assign CMD_CODE_O = cc_q;
  assign CMD_BANK_O = cb_q;
  assign CMD_ADDR_O = ca_q;
  assign CMD_AP_O = cap_q;
  assign CMD_BC4_O = cbc_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_pd_in;
    rise && pwr_q == P_ON && ckep_q && !cke && nopdes && idle;
  endsequence
  sequence s_pd_out;
    rise && pwr_q == P_PD && !ckep_q && cke && nopdes;
  endsequence
  sequence s_rd_shut;
    rise && pwr_q == P_ON && ckep_q && cke && !cs_n && ras_n && !cas_n
    && we_n && !open_q[ba];
  endsequence

  a_rd_closed_bank: assert property (s_rd_shut |=>
    CMD_STB_O && CMD_CODE_O == C_ILL) else $error("read on closed bank");
  a_chop_select: assert property (rise && code == C_WR |=>
    CMD_BC4_O == (ctrl_q[CT_OTF] ? ~$past(a[A_BC]) : ctrl_q[CT_BC4]))
    else $error("wrong chop on write");
  a_act_opens: assert property (rise && code == C_ACT |=>
    open_q[$past(ba)] && row_q[$past(ba)] == $past(a))
    else $error("activate did not open bank");
  a_prea_closes: assert property (rise && code == C_PREA |=>
    open_q == '0) else $error("precharge all left a bank open");
  a_start_col: assert property (rise && code == C_RD |=>
    col_q == $past(a[COL_W-1:0]) && arm_q) else $error("bad start column");
  a_ap_close: assert property (done && ap_q && !(rise && code == C_ACT)
    |=> !open_q[$past(b_q)]) else $error("auto precharge missed");
  a_mrs_busy: assert property (rise && pwr_q == P_ON && ckep_q && cke &&
    !cs_n && !ras_n && !cas_n && !we_n && !idle |=> CMD_CODE_O == C_ILL)
    else $error("mode set accepted with open bank");
  a_pd_entry: assert property (s_pd_in |=> pwr_q == P_PD)
    else $error("power-down entry missed");
  a_pd_exit: assert property (s_pd_out |=> pwr_q == P_ON ##1
    pwr_q == P_ON) else $error("power-down exit missed");
  a_mask_drop: assert property (cap && wr_q && !dm && !rise |=>
    keep_q == $past(keep_q)) else $error("masked beat stored");
  a_burst_len: assert property (done |->
    idx_q == last_q && (last_q == LAST_BL8 || last_q == LAST_BC4))
    else $error("burst length wrong");
  a_nop_quiet: assert property (rise && code == C_NOP && !done |=>
    open_q == $past(open_q)) else $error("no-op changed banks");

endmodule

//--- test/scd_ctrl_model.sv
module scd_ctrl_model (
  output logic        ck_o,
  output logic        cke_o,
  output logic [3:0]  cmd_n_o,
  output logic [2:0]  ba_o,
  output logic [14:0] a_o,
  output logic        dm_o,
  output logic [7:0]  dq_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Controller side of the command link
  // ****************************************

  // Free-running link clock, phase unrelated to MCLK
  initial begin
    ck_o = 1'b0;
    #137;
    forever #400 ck_o = ~ck_o;
  end

  // Start deselected with clock enable high
  initial begin
    cke_o   = 1'b1;
    cmd_n_o = 4'hF;
    ba_o    = 3'h0;
    a_o     = 15'h0000;
    dm_o    = 1'b0;
    dq_o    = 8'h00;
  end

  // One command set at a fall, held across the rise, then no-op
  task automatic cmd(input logic [3:0] enc, input logic cke,
                     input logic [2:0] ba, input logic [14:0] a,
                     input logic [7:0] base, input logic [7:0] dm,
                     input int n);
    @(negedge ck_o);
    cmd_n_o <= enc;
    cke_o   <= cke;
    ba_o    <= ba;
    a_o     <= a;
    @(negedge ck_o);
    cmd_n_o <= 4'h7;
    ba_o    <= ~ba;
    a_o     <= ~a;
    // Write beats set 50 ns ahead of each edge from the next rise on
    if (n > 0) begin
      #350;
      for (int i = 0; i < n; i++) begin
        dq_o <= base ^ 8'(i * 8'h11);
        dm_o <= dm[i];
        #400;
      end
      dq_o <= ~dq_o;
      dm_o <= ~dm_o;
    end
  endtask
endmodule

//--- test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import scd_pkg::*;

  // ****************************************
  // Signals and encodings {cs, ras, cas, we}
  // ****************************************
  localparam logic [3:0] E_ACT = 4'h3;
  localparam logic [3:0] E_RD  = 4'h5;
  localparam logic [3:0] E_WR  = 4'h4;
  localparam logic [3:0] E_PRE = 4'h2;
  localparam logic [3:0] E_MRS = 4'h0;
  localparam logic [3:0] E_REF = 4'h1;
  localparam logic [3:0] E_NOP = 4'h7;
  localparam logic [3:0] E_ZQ  = 4'h6;
  logic        mclk, resetn, ck, cke, dm, psel, pen, pwr;
  logic        pready, pslverr, stb, cap, cbc4, wv, wr_rdy, err;
  logic [3:0]  cn, code;
  logic [2:0]  ba, cbank, wbank;
  logic [14:0] a, caddr, wrow;
  logic [7:0]  dq, paddr, wkeep;
  logic [9:0]  wcol;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] wdata;
  int          fails, n_checks;
  int          stb_cnt = 0;

  scd_ctrl_model u_ctrl (.ck_o(ck), .cke_o(cke), .cmd_n_o(cn), .ba_o(ba),
    .a_o(a), .dm_o(dm), .dq_o(dq));

  scd_decoder #(.DEPTH(2)) u_dut (.MCLK_I(mclk), .RESETN_I(resetn),
    .CK_I(ck), .CKE_I(cke), .CS_N_I(cn[3]), .RAS_N_I(cn[2]),
    .CAS_N_I(cn[1]), .WE_N_I(cn[0]), .BA_I(ba), .A_I(a), .DM_I(dm),
    .DQ_I(dq), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .CMD_STB_O(stb),
    .CMD_CODE_O(code), .CMD_BANK_O(cbank), .CMD_ADDR_O(caddr),
    .CMD_AP_O(cap), .CMD_BC4_O(cbc4), .WORD_VALID_O(wv),
    .WORD_READY_I(wr_rdy), .WORD_DATA_O(wdata), .WORD_KEEP_O(wkeep),
    .WORD_BANK_O(wbank), .WORD_ROW_O(wrow), .WORD_COL_O(wcol));

  // System clock and strobe counter
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) if (stb === 1'b1) stb_cnt <= stb_cnt + 1;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // APB transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    int k;
    @(posedge mclk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= ad;
    pwdata <= wd;
    @(posedge mclk);
    pen <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      fails++;
      close_out();
    end
    rd   = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk("register", e, rd);
  endtask

  // Issue a command and compare the decoded result
  task automatic run(input logic [3:0] enc, input logic ce,
                     input logic [2:0] b, input logic [14:0] ad,
                     input logic [3:0] ec, input logic [7:0] base = 0,
                     input logic [7:0] dmk = 0, input int n = 0);
    int n0;
    int k;
    n0 = stb_cnt;
    u_ctrl.cmd(enc, ce, b, ad, base, dmk, n);
    for (k = 0; k < 8 && stb_cnt == n0; k++) @(posedge mclk);
    // A decoded command that never strobes ends the run
    if (ec != C_NOP && stb_cnt == n0) begin
      fails++;
      close_out();
    end
    if (ec == C_NOP) chk("strobes", 64'(n0), 64'(stb_cnt));
    else begin
      chk("code", ec, code);
      chk("bank", b, cbank);
      chk("addr", ad, caddr);
    end
  endtask

  // Wait for a buffered word, compare its lanes, then pop it
  task automatic pop(input logic [2:0] b, input logic [14:0] r,
                     input logic [9:0] c, input logic [7:0] base,
                     input logic [7:0] dmk, input int n, input logic ilv);
    logic [63:0] ed, msk;
    logic [7:0]  ek;
    logic [2:0]  l, i3;
    int k;
    ed  = '0;
    msk = '0;
    ek  = '0;
    for (k = 0; k < n; k++) begin
      i3 = 3'(k);
      l = ilv ? (c[2:0] ^ i3) : {c[2] ^ i3[2], c[1:0] + i3[1:0]};
      if (dmk[k]) begin
        ek[l] = 1'b1;
        ed[8*l+:8] = base ^ 8'(k * 8'h11);
        msk[8*l+:8] = 8'hFF;
      end
    end
    @(posedge mclk);
    for (k = 0; k < 20 && wv !== 1'b1; k++) @(posedge mclk);
    // A word that never arrives ends the run
    if (wv !== 1'b1) begin
      fails++;
      close_out();
    end
    chk("keep", ek, wkeep);
    chk("data", ed, wdata & msk);
    chk("wbank", b, wbank);
    chk("wrow", r, wrow);
    chk("wcol", c, wcol);
    wr_rdy <= 1'b1;
    @(posedge mclk);
    wr_rdy <= 1'b0;
  endtask

  // Hang guard
  initial begin
    #2000000;
    fails++;
    close_out();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wr_rdy = 1'b0;
    fails = 0;
    n_checks = 0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    rdchk(REG_CTRL, 32'h0);
    rdchk(REG_STAT, 32'h0);
    rdchk(REG_LAST, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("slverr", 1, err);
    chk("unmapped", 0, rd);
    $display("test registers done");
    run(4'hF, 1, 3'h1, 15'h0000, C_NOP);
    run(E_NOP, 1, 3'h1, 15'h0000, C_NOP);
    rdchk(REG_STAT, 32'h0);
    $display("test no-op done");
    run(E_ACT, 1, 3'h2, 15'h1234, C_ACT);
    run(E_ACT, 1, 3'h5, 15'h0555, C_ACT);
    rdchk(REG_STAT, 32'h24);
    run(E_MRS, 1, 3'h0, 15'h0000, C_ILL);
    run(E_RD, 1, 3'h3, 15'h0008, C_ILL);
    run(E_RD, 1, 3'h2, 15'h0008, C_RD);
    chk("bc4", 0, cbc4);
    $display("test banks done");
    run(E_WR, 1, 3'h2, 15'h0003, C_WR, 8'h5A, 8'hB7, 8);
    chk("ap", 0, cap);
    apb(1'b1, REG_CTRL, 32'h5);
    run(E_WR, 1, 3'h5, 15'h0405, C_WR, 8'hC3, 8'h0D, 4);
    chk("bc4", 1, cbc4);
    chk("ap", 1, cap);
    rdchk(REG_STAT, 32'h0804);
    run(E_WR, 1, 3'h2, 15'h1000, C_WR, 8'h11, 8'hFF, 8);
    chk("bc4", 0, cbc4);
    rdchk(REG_STAT, 32'h1804);
    apb(1'b1, REG_STAT, 32'h1800);
    rdchk(REG_STAT, 32'h0004);
    pop(3'h2, 15'h1234, 10'h003, 8'h5A, 8'hB7, 8, 1'b0);
    pop(3'h5, 15'h0555, 10'h005, 8'hC3, 8'h0D, 4, 1'b1);
    @(posedge mclk);
    chk("valid", 0, wv);
    apb(1'b1, REG_CTRL, 32'h2);
    run(E_RD, 1, 3'h2, 15'h1404, C_RD);
    chk("bc4", 1, cbc4);
    chk("ap", 1, cap);
    repeat (30) @(posedge mclk);
    rdchk(REG_STAT, 32'h0);
    $display("test writes done");
    run(E_PRE, 1, 3'h2, 15'h0000, C_PRE);
    rdchk(REG_STAT, 32'h0);
    run(E_ACT, 1, 3'h1, 15'h0042, C_ACT);
    run(E_PRE, 1, 3'h0, 15'h0400, C_PREA);
    rdchk(REG_STAT, 32'h0);
    run(E_MRS, 1, 3'h3, 15'h0ABC, C_MRS);
    run(E_ZQ, 1, 3'h0, 15'h0400, C_ZQL);
    run(E_ZQ, 1, 3'h0, 15'h0000, C_ZQS);
    run(E_REF, 1, 3'h0, 15'h0000, C_REF);
    $display("test idle commands done");
    run(E_NOP, 0, 3'h0, 15'h0000, C_PDE);
    rdchk(REG_STAT, 32'h100);
    run(E_ACT, 0, 3'h4, 15'h0001, C_NOP);
    run(E_NOP, 1, 3'h0, 15'h0000, C_PDX);
    run(E_REF, 0, 3'h0, 15'h0000, C_SRE);
    rdchk(REG_STAT, 32'h200);
    run(E_NOP, 1, 3'h0, 15'h0000, C_SRX);
    rdchk(REG_LAST, 32'h9);
    $display("test power done");
    close_out();
  end
endmodule
